// >>> low_power_wakeup_sequencer_test.sv
/*
  Self-checking bench of the wake-up sequencer with its wake source model.
  Assumes the package cycle counts at a 10 MHz clock.
*/
module low_power_wakeup_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys          = 1'b0;
  logic        resetn           = 1'b0;
  logic        enter_req        = 1'b0;
  logic [2:0]  enter_mode       = 3'h0;
  logic [7:0]  wake_en_timer    = 8'hFF;
  logic [7:0]  wake_en_stop     = 8'hFF;
  logic        rst_wake_en_stop = 1'b0;
  logic [1:0]  clk_sel          = 2'h0;
  logic [13:0] main_stab_cyc    = 14'h0014;
  logic [13:0] pll_stab_cyc     = 14'h001E;
  wire  [7:0]  irq;
  wire         por, ext_n, wdg, sup_rst;
  logic        cpu_run, cpu_reset, clk_ready;
  logic [2:0]  cur_mode;
  logic [1:0]  cur_clk;
  int          n_fail, num_checks, n;

  always #50 clk_sys = ~clk_sys;

  lpws_wake_src #(.N_IRQ(8)) lpws_wake_src_inst (.clk_sys(clk_sys),
    .irq(irq), .por_lvd_active(por), .external_reset_pin_n(ext_n),
    .watchdog_reset(wdg), .clock_supervisor_reset(sup_rst));

  lpws_sequencer #(.N_IRQ(8), .STAB_W(14)) lpws_sequencer_inst (
    .clk_sys(clk_sys), .resetn(resetn), .por_lvd_active(por),
    .external_reset_pin_n(ext_n), .watchdog_reset(wdg),
    .clock_supervisor_reset(sup_rst), .enter_req(enter_req),
    .enter_mode(enter_mode), .irq(irq), .wake_en_timer(wake_en_timer),
    .wake_en_stop(wake_en_stop), .rst_wake_en_stop(rst_wake_en_stop),
    .clk_sel(clk_sel), .main_stab_cyc(main_stab_cyc),
    .pll_stab_cyc(pll_stab_cyc), .cpu_run(cpu_run),
    .cpu_reset(cpu_reset), .cur_mode(cur_mode), .cur_clk(cur_clk),
    .clk_ready(clk_ready));

  task automatic chk_v(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  // Small slack covers the pipeline stages around the count
  task automatic chk_lat(input int got, input int lo);
    num_checks++;
    if (got < lo || got > lo + 5) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask : chk_lat

  task automatic wait_run(output int k);
    k = 0;
    while (cpu_run !== 1'b1 && k < 12000) begin
      @(negedge clk_sys);
      k++;
    end
  endtask : wait_run

  task automatic enter(input logic [2:0] m);
    @(negedge clk_sys);
    enter_req  = 1'b1;
    enter_mode = m;
    @(negedge clk_sys);
    enter_req = 1'b0;
    chk_v({2'h0, cpu_run}, 3'h0);
  endtask : enter

  task automatic irq_wake(input logic [2:0] m, input int i, input int lo);
    enter(m);
    @(negedge clk_sys);
    lpws_wake_src_inst.irq_set(i, 1'b1);
    wait_run(n);
    chk_lat(n, lo);
    lpws_wake_src_inst.irq_set(i, 1'b0);
    chk_v(cur_mode, 3'h0);
  endtask : irq_wake

  task automatic rst_wake(input logic [2:0] m, input int k, input int lo);
    enter(m);
    clk_sel = 2'h0;
    lpws_wake_src_inst.rst_pulse(k, 10);
    wait_run(n);
    chk_lat(n, lo);
    chk_v({1'b0, cur_clk}, 3'h0);
  endtask : rst_wake

  task automatic t_power;
    repeat (10) @(negedge clk_sys);
    chk_v({cpu_reset, cpu_run, clk_ready}, 3'h5);
    chk_v(cur_mode, 3'h0);
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    wait_run(n);
    chk_lat(n, lpws_pkg::RST_FAST_CYC);
    chk_v({1'b0, cur_clk}, 3'h0);
    $display("test power done");
  endtask : t_power

  task automatic t_modes;
    for (int m = 1; m <= 4; m++) irq_wake(3'(m), m, 330);
    for (int m = 5; m <= 7; m++) irq_wake(3'(m), m, 4450);
    $display("test modes done");
  endtask : t_modes

  task automatic t_clock;
    @(negedge clk_sys);
    clk_sel = 2'h1;
    @(negedge clk_sys);
    chk_v({2'h0, clk_ready}, 3'h0);
    n = 1;
    while (clk_ready !== 1'b1 && n < 60) begin
      @(negedge clk_sys);
      n++;
    end
    chk_lat(n, 19);
    irq_wake(3'h2, 0, 330);
    chk_v({1'b0, cur_clk}, 3'h1);
    rst_wake(3'h4, 2, 1810);
    $display("test clock done");
  endtask : t_clock

  task automatic t_mask;
    wake_en_timer = 8'hFE;
    enter(3'h2);
    lpws_wake_src_inst.irq_set(0, 1'b1);
    repeat (500) @(negedge clk_sys);
    chk_v({2'h0, cpu_run}, 3'h0);
    lpws_wake_src_inst.irq_set(0, 1'b0);
    lpws_wake_src_inst.irq_set(1, 1'b1);
    wait_run(n);
    chk_lat(n, 330);
    lpws_wake_src_inst.irq_set(1, 1'b0);
    wake_en_stop = 8'h01;
    enter(3'h7);
    lpws_wake_src_inst.rst_pulse(1, 10);
    repeat (500) @(negedge clk_sys);
    chk_v({2'h0, cpu_run}, 3'h0);
    lpws_wake_src_inst.irq_set(0, 1'b1);
    wait_run(n);
    chk_lat(n, 4450);
    lpws_wake_src_inst.irq_set(0, 1'b0);
    wake_en_timer = 8'hFF;
    $display("test mask done");
  endtask : t_mask

  task automatic t_reset;
    rst_wake(3'h7, 0, 10030);
    rst_wake_en_stop = 1'b1;
    rst_wake(3'h7, 1, 10030);
    rst_wake(3'h1, 0, 1810);
    lpws_wake_src_inst.rst_pulse(3, 500);
    wait_run(n);
    chk_lat(n, 1810);
    $display("test reset done");
  endtask : t_reset

  task automatic t_coincide;
    @(negedge clk_sys);
    enter_req  = 1'b1;
    enter_mode = 3'h7;
    lpws_wake_src_inst.irq_set(0, 1'b1);
    @(negedge clk_sys);
    enter_req = 1'b0;
    wait_run(n);
    chk_lat(n + 1, 4450);
    lpws_wake_src_inst.irq_set(0, 1'b0);
    $display("test coincide done");
  endtask : t_coincide

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  initial begin
    #9000000;
    n_fail++;
    close_out();
  end

  initial begin
    t_power();
    t_modes();
    t_clock();
    t_mask();
    t_reset();
    t_coincide();
    close_out();
  end
endmodule : low_power_wakeup_sequencer_test

// >>> lpws_cnt_if.sv
/*
  Carrier between the sequencer and its latency counter.
  Assumes both sides share clk_sys.
*/
interface lpws_cnt_if;
  logic                       start;
  logic [lpws_pkg::CNT_W-1:0] load;
  logic                       done;
  logic                       busy;
  modport ctl (output start, output load, input done, input busy);
  modport cnt (input start, input load, output done, output busy);
endinterface : lpws_cnt_if

// >>> lpws_counter.sv
/*
  Down counter timing the wake-up latency.
  Assumes clk_sys comes from the built-in oscillator; a load of zero is
  treated as one cycle.
*/
module lpws_counter (
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  lpws_cnt_if.cnt     cnt
);
  logic [lpws_pkg::CNT_W-1:0] cnt_ff;
  logic                       busy_ff;
  wire  logic                 last = (cnt_ff <= lpws_pkg::CNT_W'(1));

  // Counts on the oscillator clock, so latency tracks its tolerance
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
    end else if (cnt.start) begin
      cnt_ff  <= cnt.load;
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      cnt_ff  <= last ? '0 : cnt_ff - lpws_pkg::CNT_W'(1);
      busy_ff <= !last;
    end
  end

  assign cnt.done = busy_ff && last;
  assign cnt.busy = busy_ff;
endmodule : lpws_counter

// >>> lpws_pkg.sv
/*
  Shared constants and types of the low-power wake-up sequencer.
  Assumes a single 10 MHz system clock derived from the built-in oscillator.
*/
package lpws_pkg;
  localparam int unsigned CLK_KHZ       = 10000;
  // Return times, in microseconds as specified
  localparam int unsigned IRQ_FAST_US   = 33;
  localparam int unsigned IRQ_FAST_MAX  = 100;
  localparam int unsigned IRQ_SLOW_US   = 445;
  localparam int unsigned IRQ_SLOW_MAX  = 1061;
  localparam int unsigned RST_FAST_MAX  = 181;
  localparam int unsigned RST_SLOW_MAX  = 1003;
  // Cycle counts: typical figure used as the irq wait, max as the reset wait, rounds down
  localparam int unsigned IRQ_FAST_CYC  = IRQ_FAST_US * CLK_KHZ / 1000;
  localparam int unsigned IRQ_SLOW_CYC  = IRQ_SLOW_US * CLK_KHZ / 1000;
  localparam int unsigned IRQ_FMAX_CYC  = IRQ_FAST_MAX * CLK_KHZ / 1000;
  localparam int unsigned IRQ_SMAX_CYC  = IRQ_SLOW_MAX * CLK_KHZ / 1000;
  localparam int unsigned RST_FAST_CYC  = RST_FAST_MAX * CLK_KHZ / 1000;
  localparam int unsigned RST_SLOW_CYC  = RST_SLOW_MAX * CLK_KHZ / 1000;
  localparam int unsigned CNT_W         = 14;

  typedef enum logic [2:0] {
    LPWS_MODE_RUN   = 3'h0,
    LPWS_MODE_SLEEP = 3'h1,
    LPWS_MODE_HSCR  = 3'h2,
    LPWS_MODE_MAIN  = 3'h3,
    LPWS_MODE_PLL   = 3'h4,
    LPWS_MODE_LSCR  = 3'h5,
    LPWS_MODE_SUB   = 3'h6,
    LPWS_MODE_STOP  = 3'h7
  } lpws_mode_e;

  typedef enum logic [1:0] {
    LPWS_CLK_HSCR = 2'h0,
    LPWS_CLK_MAIN = 2'h1,
    LPWS_CLK_PLL  = 2'h2,
    LPWS_CLK_LSCR = 2'h3
  } lpws_clk_e;
endpackage : lpws_pkg

// >>> lpws_sequencer.sv
/*
  Wake-up sequencer: holds the core in a low-power mode and times the return
  to program execution after an interrupt or reset return factor.
  Assumes all inputs are synchronous to clk_sys; power-on and low-voltage
  reset arrive as a level on por_lvd_active.
*/
// How it works
// - Interrupt latency counts from the return factor to program start.
// - Fast timer modes resume after 33 us typical, 100 us at most.
// - Slow timer and stop modes resume after 445 us, 1061 us at most.
// - Reset return runs within 181 us fast, 1003 us slow, from release.
// - Time under power-on or low-voltage reset is not counted.
// - After reset run from high-speed oscillator; main or PLL adds a wait.
// - Watchdog and clock supervisor resets count as wake-up factors.
// - Interrupt wake returns to the mode used before entry.
// - Sleep accepts any irq, stop uses wake_en_stop, all other low-power modes share wake_en_timer.
// - An interrupt coinciding with mode entry still wakes the device.
module lpws_sequencer #(
  parameter int unsigned N_IRQ   = 8,
  parameter int unsigned STAB_W  = 14
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               por_lvd_active,
  input  wire logic               external_reset_pin_n,
  input  wire logic               watchdog_reset,
  input  wire logic               clock_supervisor_reset,
  input  wire logic               enter_req,
  input  wire logic [2:0]         enter_mode,
  input  wire logic [N_IRQ-1:0]   irq,
  input  wire logic [N_IRQ-1:0]   wake_en_timer,
  input  wire logic [N_IRQ-1:0]   wake_en_stop,
  input  wire logic               rst_wake_en_stop,
  input  wire logic [1:0]         clk_sel,
  input  wire logic [STAB_W-1:0]  main_stab_cyc,
  input  wire logic [STAB_W-1:0]  pll_stab_cyc,
  output logic                    cpu_run,
  output logic                    cpu_reset,
  output logic [2:0]              cur_mode,
  output logic [1:0]              cur_clk,
  output logic                    clk_ready
);
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_RWAIT = 3'h1,
    ST_RUN   = 3'h2,
    ST_LOWP  = 3'h3,
    ST_IWAIT = 3'h4
  } lpws_state_e;

  lpws_state_e          state_ff, nxt_state;
  lpws_pkg::lpws_mode_e mode_ff;
  logic [1:0]           run_clk_ff;
  logic [1:0]           clk_ff;
  logic [STAB_W-1:0]    stab_ff;
  logic                 run_ff;

  lpws_cnt_if cif ();
  lpws_counter u_cnt (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .cnt     (cif.cnt)
  );

  function automatic logic is_slow(input logic [2:0] m);
    return m == lpws_pkg::LPWS_MODE_LSCR || m == lpws_pkg::LPWS_MODE_SUB ||
           m == lpws_pkg::LPWS_MODE_STOP;
  endfunction : is_slow

  wire logic        res_src = !external_reset_pin_n || watchdog_reset ||
                              clock_supervisor_reset;
  wire logic        in_stop = (mode_ff == lpws_pkg::LPWS_MODE_STOP);
  wire logic        in_sleep = (mode_ff == lpws_pkg::LPWS_MODE_SLEEP);
  // Stop drops internal resets unless allowed; sleep takes any irq
  wire logic        rst_ok = !external_reset_pin_n ||
                             ((watchdog_reset || clock_supervisor_reset) &&
                              (!in_stop || rst_wake_en_stop));
  wire logic [N_IRQ-1:0] en_mask = in_sleep ? {N_IRQ{1'b1}} :
                                   in_stop ? wake_en_stop : wake_en_timer;
  wire logic        irq_wake = |(irq & en_mask);
  // Pending irq at entry is checked against the target mode
  wire logic [N_IRQ-1:0] ent_mask =
    (enter_mode == lpws_pkg::LPWS_MODE_SLEEP) ? {N_IRQ{1'b1}} :
    (enter_mode == lpws_pkg::LPWS_MODE_STOP) ? wake_en_stop : wake_en_timer;
  wire logic        ent_wake = |(irq & ent_mask);
  // Entry with a pending irq has no stored mode yet; use the target mode
  wire logic [2:0]  load_mode = (state_ff == ST_RUN) ? enter_mode : mode_ff;
  wire logic [lpws_pkg::CNT_W-1:0] irq_load =
    is_slow(load_mode) ? lpws_pkg::CNT_W'(lpws_pkg::IRQ_SLOW_CYC)
                       : lpws_pkg::CNT_W'(lpws_pkg::IRQ_FAST_CYC);
  wire logic [lpws_pkg::CNT_W-1:0] rst_load =
    is_slow(mode_ff) ? lpws_pkg::CNT_W'(lpws_pkg::RST_SLOW_CYC)
                     : lpws_pkg::CNT_W'(lpws_pkg::RST_FAST_CYC);
  wire logic        lowp_irq = (state_ff == ST_LOWP) && irq_wake && !rst_ok;
  wire logic        stab_done = (stab_ff == '0);

  // Reset outranks interrupt; count starts only once reset is released
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RESET: if (!por_lvd_active && !res_src) nxt_state = ST_RWAIT;
      ST_RWAIT: if (cif.done) nxt_state = ST_RUN;
      ST_RUN:   if (enter_req && enter_mode != lpws_pkg::LPWS_MODE_RUN)
                  nxt_state = ent_wake ? ST_IWAIT : ST_LOWP;
      ST_LOWP:  if (irq_wake) nxt_state = ST_IWAIT;
      ST_IWAIT: if (cif.done) nxt_state = ST_RUN;
      default:  nxt_state = ST_RESET;
    endcase
    // Masked internal resets in low power are left to rst_ok
    if (por_lvd_active || (res_src && state_ff != ST_LOWP))
      nxt_state = ST_RESET;
    if (state_ff == ST_LOWP && rst_ok) nxt_state = ST_RESET;
  end

  assign cif.start = (state_ff == ST_RESET && nxt_state == ST_RWAIT) ? 1'b1 :
                     (nxt_state == ST_IWAIT && state_ff != ST_IWAIT);
  assign cif.load  = (state_ff == ST_RESET) ? rst_load : irq_load;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) state_ff <= ST_RESET;
    else         state_ff <= nxt_state;
  end

  // Mode entered is kept through reset so the reset count knows it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= lpws_pkg::LPWS_MODE_RUN;
    end else if (state_ff == ST_RUN && nxt_state != ST_RUN &&
                 nxt_state != ST_RESET) begin
      mode_ff <= lpws_pkg::lpws_mode_e'(enter_mode);
    end else if ((state_ff == ST_RWAIT || state_ff == ST_IWAIT) &&
                 cif.done) begin
      // Back in run after either wait, as before entry
      mode_ff <= lpws_pkg::LPWS_MODE_RUN;
    end
  end

  // Clock in use: high-speed after reset, prior run clock after irq
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_clk_ff <= lpws_pkg::LPWS_CLK_HSCR;
      clk_ff     <= lpws_pkg::LPWS_CLK_HSCR;
      stab_ff    <= '0;
    end else if (state_ff == ST_RESET) begin
      run_clk_ff <= lpws_pkg::LPWS_CLK_HSCR;
      clk_ff     <= lpws_pkg::LPWS_CLK_HSCR;
      stab_ff    <= '0;
    end else if (state_ff == ST_RUN && clk_sel != clk_ff) begin
      clk_ff     <= clk_sel;
      run_clk_ff <= clk_sel;
      // Oscillator or PLL must settle before the clock is reported ready
      stab_ff    <= (clk_sel == lpws_pkg::LPWS_CLK_MAIN) ? main_stab_cyc :
                    (clk_sel == lpws_pkg::LPWS_CLK_PLL) ? pll_stab_cyc :
                    '0;
    end else if (state_ff == ST_IWAIT) begin
      clk_ff <= run_clk_ff;
    end else if (!stab_done) begin
      stab_ff <= stab_ff - STAB_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) run_ff <= 1'b0;
    else         run_ff <= (nxt_state == ST_RUN);
  end

  assign cpu_run   = run_ff;
  assign cpu_reset = (state_ff == ST_RESET);
  assign cur_mode  = mode_ff;
  assign cur_clk   = clk_ff;
  assign clk_ready = stab_done;

  // Slow irq and fast reset waits are bounded on a cycle count, not a long delay range,
  // which would be slow to evaluate
  localparam int unsigned IRQ_SLOW_LIM = lpws_pkg::IRQ_SLOW_CYC + 5;
  localparam int unsigned RST_FAST_LIM = lpws_pkg::RST_FAST_CYC + 1;
  logic [lpws_pkg::CNT_W-1:0] wait_cyc_ff;
  wire  logic                 in_wait = (state_ff == ST_RWAIT) ||
                                        (state_ff == ST_IWAIT);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)      wait_cyc_ff <= '0;
    else if (in_wait) wait_cyc_ff <= wait_cyc_ff + lpws_pkg::CNT_W'(1);
    else              wait_cyc_ff <= '0;
  end

  a_irq_fast_time: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    lowp_irq && !is_slow(mode_ff) && !por_lvd_active && !res_src
    |-> ##[1:331] cpu_run || cpu_reset)
    else $error("fast irq wake late");
  a_irq_slow_time: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state_ff == ST_IWAIT && is_slow(mode_ff) |-> wait_cyc_ff < IRQ_SLOW_LIM)
    else $error("slow irq wake late");
  a_irq_no_early: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    lowp_irq && !is_slow(mode_ff) |-> !cpu_run [*8])
    else $error("irq wake too early");
  a_rst_hold: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    por_lvd_active |=> cpu_reset)
    else $error("reset not held");
  a_rst_hscr: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(cpu_reset) |-> cur_clk == lpws_pkg::LPWS_CLK_HSCR)
    else $error("reset not on fast osc");
  a_rst_fast: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state_ff == ST_RWAIT && !is_slow(mode_ff) |-> wait_cyc_ff < RST_FAST_LIM)
    else $error("reset wake late");
  a_wdt_wake: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state_ff == ST_LOWP && watchdog_reset && !in_stop |=> cpu_reset)
    else $error("watchdog did not wake");
  a_entry_race: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state_ff == ST_RUN && enter_req && ent_wake && !res_src &&
    !por_lvd_active && enter_mode != 3'h0 |=> state_ff == ST_IWAIT)
    else $error("entry race lost");
  a_irq_mode: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state_ff == ST_IWAIT && cif.done && !res_src && !por_lvd_active
    |=> cur_clk == run_clk_ff && cur_mode == lpws_pkg::LPWS_MODE_RUN)
    else $error("mode not restored");
  a_stop_mask: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    state_ff == ST_LOWP && in_stop && !(|(irq & wake_en_stop)) && !rst_ok
    && !por_lvd_active |=> state_ff == ST_LOWP)
    else $error("masked factor woke stop");
  a_cnt_busy: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    in_wait |-> cif.busy)
    else $error("wait without count");
endmodule : lpws_sequencer

// >>> lpws_wake_src.sv
/*
  Wake source model: interrupt lines and reset inputs of the sequencer.
  Assumes the bench calls its tasks at a falling clock edge.
*/
module lpws_wake_src #(
  parameter int unsigned N_IRQ = 8
) (
  input  wire logic        clk_sys,
  output logic [N_IRQ-1:0] irq,
  output logic             por_lvd_active,
  output logic             external_reset_pin_n,
  output logic             watchdog_reset,
  output logic             clock_supervisor_reset
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    irq                    = '0;
    por_lvd_active         = 1'b0;
    external_reset_pin_n   = 1'b1;
    watchdog_reset         = 1'b0;
    clock_supervisor_reset = 1'b0;
  end

  // Caller is already at a falling edge, so entry can coincide
  task automatic irq_set(input int idx, input logic v);
    irq[idx] = v;
  endtask : irq_set

  function automatic void set_rst(input int kind, input logic v);
    case (kind)
      0: external_reset_pin_n = ~v;
      1: watchdog_reset = v;
      2: clock_supervisor_reset = v;
      default: por_lvd_active = v;
    endcase
  endfunction : set_rst

  task automatic rst_pulse(input int kind, input int cyc);
    @(negedge clk_sys);
    set_rst(kind, 1'b1);
    repeat (cyc) @(negedge clk_sys);
    set_rst(kind, 1'b0);
  endtask : rst_pulse
endmodule : lpws_wake_src
